// [verilog/i2css_consts.svh]
// Offsets, field positions, status codes and timing of the slave engine.
// What this block does
// RQ1: After acked general-call data ack_enable sets the next ack.
// RQ2: Clearing after nacked general-call data unaddresses.
// RQ3: Clearing with start_request sends START on a free bus.
// RQ4: STOP or repeated START while addressed has own status.
// RQ5: Upper seven own address bits match the bus address.
// RQ6: Own address bit zero enables the general call.
// RQ7: Software sets interface_enable and ack_enable only.
// RQ8: A matched read address transmits, a write receives.
// RQ9: Own address and direction raise the flag with status.
// RQ10: Lost arbitration then own read address has own status.
// RQ11: Clear ack_enable sends a last byte; master reply picks status.
// RQ12: After the last byte the data line stays released.
// RQ13: With ack_enable clear no address is acked; set resumes.
// RQ14: Deep sleep match is acked on the bus clock and wakes.
// RQ15: A wake match holds the clock low until the flag clears.
// RQ16: After a wake the data register may hold a stale byte.
// RQ17: Status is read with prescaler bits zero or masked.
// RQ18: Nacked own-address data has own status; clear unaddresses.
// RQ19: Acked own read address has status; ack_enable marks last.
`ifndef I2CSS_CONSTS_SVH
`define I2CSS_CONSTS_SVH

`define I2CSS_A_OWN     2'h0
`define I2CSS_A_CTL     2'h1
`define I2CSS_A_STAT    2'h2
`define I2CSS_A_DATA    2'h3

`define I2CSS_C_FLAG    7
`define I2CSS_C_ACK     6
`define I2CSS_C_START   5
`define I2CSS_C_STOP    4
`define I2CSS_C_WCOL    3
`define I2CSS_C_EN      2
`define I2CSS_C_IE      0

`define I2CSS_OWN_RST   8'h00
`define I2CSS_GCALL     7'h00

`define I2CSS_S_NONE    8'hF8
`define I2CSS_S_START   8'h08
`define I2CSS_S_SLA_W   8'h60
`define I2CSS_S_ARB_W   8'h68
`define I2CSS_S_GC      8'h70
`define I2CSS_S_ARB_GC  8'h78
`define I2CSS_S_RX_ACK  8'h80
`define I2CSS_S_RX_NACK 8'h88
`define I2CSS_S_GC_ACK  8'h90
`define I2CSS_S_GC_NACK 8'h98
`define I2CSS_S_STOP    8'hA0
`define I2CSS_S_SLA_R   8'hA8
`define I2CSS_S_ARB_R   8'hB0
`define I2CSS_S_TX_ACK  8'hB8
`define I2CSS_S_TX_NACK 8'hC0
`define I2CSS_S_TX_LAST 8'hC8

`define I2CSS_LINK_NS   64
`define I2CSS_THDSTA_NS 4000
`define I2CSS_LRST_CYC  6'h3F

`endif

// [verilog/i2css_pkg.sv]
// Types shared by the slave engine and its crossings.
package i2css_pkg;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] data;
	} i2css_evt_t;

	typedef struct packed {
		logic [7:0] data;
		logic       ack;
		logic       start;
	} i2css_rsp_t;

	typedef struct packed {
		logic [7:0] own;
		logic       ack;
		logic       en;
		logic       arb;
	} i2css_cfg_t;

	typedef enum logic [1:0] {NX_RX, NX_TX, NX_FREE} i2css_next_t;

	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_AACK, LK_RX, LK_RACK,
		LK_TX, LK_TACK, LK_WAIT, LK_FREE, LK_GEN
	} i2css_lstate_t;

endpackage

// [verilog/i2css_sync.sv]
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module i2css_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk, // Destination clock.
	input  wire logic [W-1:0] i_d,   // Asynchronous levels.
	output logic      [W-1:0] o_q    // Synchronised levels.
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk)
	begin
		meta_q <= i_d;
		o_q    <= meta_q;
	end
endmodule // i2css_sync

// [verilog/i2css_xfer.sv]
// Toggle handshake that carries one word between two clock domains.
`timescale 1ns/1ps
module i2css_xfer #(
	parameter int W = 8
) (
	input  wire logic         i_sclk,   // Source clock.
	input  wire logic         i_srst,   // Source reset.
	input  wire logic         i_svalid, // Send request, taken if not busy.
	input  wire logic [W-1:0] i_sdata,  // Word to send.
	output logic              o_sbusy,  // Previous word not yet taken.
	input  wire logic         i_dclk,   // Destination clock.
	input  wire logic         i_drst,   // Destination reset.
	output logic              o_dvalid, // One-cycle arrival pulse.
	output logic      [W-1:0] o_ddata   // Arrived word.
);
	logic         req_q;
	logic         req_s;
	logic         seen_q;
	logic         ack_s;
	logic [W-1:0] hold_q;

	// The held word is still until the toggle returns, so copying is safe.
	always_ff @(posedge i_sclk)
	begin
		if (i_srst)
		begin
			req_q  <= 1'b0;
			hold_q <= '0;
		end
		else if (i_svalid && !o_sbusy)
		begin
			req_q  <= ~req_q;
			hold_q <= i_sdata;
		end
	end

	assign o_sbusy = req_q != ack_s;

	i2css_sync #(.W(1)) u_req_sync (
		.i_clk (i_dclk),
		.i_d   (req_q),
		.o_q   (req_s)
	);

	i2css_sync #(.W(1)) u_ack_sync (
		.i_clk (i_sclk),
		.i_d   (seen_q),
		.o_q   (ack_s)
	);

	always_ff @(posedge i_dclk)
	begin
		if (i_drst)
		begin
			seen_q   <= 1'b0;
			o_dvalid <= 1'b0;
			o_ddata  <= '0;
		end
		else
		begin
			seen_q   <= req_s;
			o_dvalid <= req_s != seen_q;
			if (req_s != seen_q)
				o_ddata <= hold_q;
		end
	end
endmodule // i2css_xfer

// [verilog/i2css_top.sv]
// Slave-side two-wire status engine with register port and bus engine.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "i2css_consts.svh"
module i2css_top (
	input  wire logic       i_clk,        // System clock, 200 MHz.
	input  wire logic       i_rst,        // Synchronous reset, high.
	input  wire logic [1:0] i_addr,       // Register index.
	input  wire logic [7:0] i_wdata,      // Write data.
	input  wire logic       i_wr,         // Write strobe.
	input  wire logic       i_rd,         // Read strobe.
	output logic      [7:0] o_rdata,      // Read data, cycle after i_rd.
	input  wire logic       i_arb_lost,   // Master lost arbitration pulse.
	input  wire logic       i_deep_sleep, // Deep sleep level.
	input  wire logic       i_link_clk,   // Bus sampling clock.
	input  wire logic       i_scl,        // Clock line level.
	input  wire logic       i_sda,        // Data line level.
	output logic            o_scl_out,    // Clock line drive value.
	output logic            o_scl_oe,     // Clock line pulled low.
	output logic            o_sda_out,    // Data line drive value.
	output logic            o_sda_oe,     // Data line pulled low.
	output logic            o_wake        // Wake request.
);
	localparam int HOLD_CYC =
		(`I2CSS_THDSTA_NS + `I2CSS_LINK_NS - 1) / `I2CSS_LINK_NS;

	// ----------------------------------------------------------------
	// System-side registers
	// ----------------------------------------------------------------
	logic [7:0] own_q;
	logic       ack_q;
	logic       start_q;
	logic       stop_q;
	logic       en_q;
	logic       ie_q;
	logic [1:0] presc_q;
	logic       flag_q;
	logic       wcol_q;
	logic       arb_q;
	logic       cfg_pend_q;
	logic [7:0] status_q;
	logic [7:0] data_q;
	logic [7:0] rdata_q;
	logic       clear_w;
	logic       cfg_send;
	logic       cfg_busy;
	logic       evt_v;
	logic       evt_data;
	logic       evt_arb;

	i2css_pkg::i2css_evt_t evt;
	i2css_pkg::i2css_cfg_t cfg_w;
	i2css_pkg::i2css_rsp_t rsp_w;

	assign clear_w  = i_wr && i_addr == `I2CSS_A_CTL &&
		i_wdata[`I2CSS_C_FLAG];
	assign cfg_send = cfg_pend_q && !cfg_busy;
	assign cfg_w    = '{own: own_q, ack: ack_q, en: en_q, arb: arb_q};
	assign rsp_w    = '{data: data_q, ack: i_wdata[`I2CSS_C_ACK],
		start: i_wdata[`I2CSS_C_START]};
	assign evt_data = evt.code == `I2CSS_S_RX_ACK ||
		evt.code == `I2CSS_S_RX_NACK || evt.code == `I2CSS_S_GC_ACK ||
		evt.code == `I2CSS_S_GC_NACK;
	assign evt_arb  = evt.code == `I2CSS_S_ARB_W ||
		evt.code == `I2CSS_S_ARB_GC || evt.code == `I2CSS_S_ARB_R;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			own_q   <= `I2CSS_OWN_RST;
			ack_q   <= 1'b0;
			start_q <= 1'b0;
			stop_q  <= 1'b0;
			en_q    <= 1'b0;
			ie_q    <= 1'b0;
			presc_q <= 2'h0;
		end
		else
		begin
			if (i_wr && i_addr == `I2CSS_A_OWN)
				own_q <= i_wdata;
			if (i_wr && i_addr == `I2CSS_A_CTL)
			begin
				ack_q   <= i_wdata[`I2CSS_C_ACK];
				start_q <= i_wdata[`I2CSS_C_START];
				stop_q  <= i_wdata[`I2CSS_C_STOP];
				en_q    <= i_wdata[`I2CSS_C_EN];
				ie_q    <= i_wdata[`I2CSS_C_IE];
			end
			if (i_wr && i_addr == `I2CSS_A_STAT)
				presc_q <= i_wdata[1:0];
			if (clear_w)
				stop_q <= 1'b0;
			// A START that went out has served the request.
			if (evt_v && evt.code == `I2CSS_S_START)
				start_q <= 1'b0;
		end
	end

	// The event sets the flag even when a clear lands in the same cycle.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			flag_q <= 1'b0;
		else
			flag_q <= evt_v || (flag_q && !clear_w);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			status_q <= `I2CSS_S_NONE;
			data_q   <= 8'h00;
		end
		else if (evt_v)
		begin
			status_q <= evt.code; // RQ9
			// Address events keep the data byte, stale after a wake.
			if (evt_data)
				data_q <= evt.data; // RQ16
		end
		else if (i_wr && i_addr == `I2CSS_A_DATA && flag_q)
			data_q <= i_wdata;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			wcol_q <= 1'b0;
		else if (i_wr && i_addr == `I2CSS_A_DATA)
			wcol_q <= !flag_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			arb_q <= 1'b0;
		else
			arb_q <= i_arb_lost || (arb_q && !(evt_v && evt_arb)); // RQ10
	end

	// Any change the bus engine must see is resent as one word.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cfg_pend_q <= 1'b0;
		else
			cfg_pend_q <= (cfg_pend_q && cfg_busy) || i_arb_lost ||
				(evt_v && evt_arb) ||
				(i_wr && (i_addr == `I2CSS_A_OWN || i_addr == `I2CSS_A_CTL));
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rdata_q <= 8'h00;
		else if (!i_rd)
			rdata_q <= 8'h00;
		else
		begin
			case (i_addr)
				`I2CSS_A_OWN:  rdata_q <= own_q;
				`I2CSS_A_CTL:  rdata_q <= {flag_q, ack_q, start_q, stop_q,
					wcol_q, en_q, 1'b0, ie_q};
				`I2CSS_A_STAT: rdata_q <= {flag_q ? status_q[7:3] :
					5'(`I2CSS_S_NONE >> 3), 1'b0, presc_q};
				default:       rdata_q <= data_q;
			endcase
		end
	end

	assign o_rdata = rdata_q;

	// ----------------------------------------------------------------
	// Domain crossings
	// ----------------------------------------------------------------
	logic                  lrst;
	logic                  sleep_s;
	logic [1:0]            pin_s;
	logic                  rsp_v;
	logic                  cfg_v;
	i2css_pkg::i2css_rsp_t rsp;
	i2css_pkg::i2css_cfg_t cfg_in;
	i2css_pkg::i2css_evt_t evt_q;
	logic                  evt_v_q;
	logic [5:0]            lrst_cnt_q;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			lrst_cnt_q <= `I2CSS_LRST_CYC;
		else if (lrst_cnt_q != 6'h00)
			lrst_cnt_q <= lrst_cnt_q - 6'h01;
	end

	i2css_sync #(.W(2)) u_lvl_sync (
		.i_clk (i_link_clk),
		.i_d   ({lrst_cnt_q != 6'h00, i_deep_sleep}),
		.o_q   ({lrst, sleep_s})
	);

	i2css_sync #(.W(2)) u_pin_sync (
		.i_clk (i_link_clk),
		.i_d   ({i_scl, i_sda}),
		.o_q   (pin_s)
	);

	i2css_xfer #(.W(11)) u_cfg_xfer (
		.i_sclk   (i_clk),
		.i_srst   (i_rst),
		.i_svalid (cfg_send),
		.i_sdata  (cfg_w),
		.o_sbusy  (cfg_busy),
		.i_dclk   (i_link_clk),
		.i_drst   (lrst),
		.o_dvalid (cfg_v),
		.o_ddata  (cfg_in)
	);

	i2css_xfer #(.W(10)) u_rsp_xfer (
		.i_sclk   (i_clk),
		.i_srst   (i_rst),
		.i_svalid (clear_w && flag_q),
		.i_sdata  (rsp_w),
		.o_sbusy  (),
		.i_dclk   (i_link_clk),
		.i_drst   (lrst),
		.o_dvalid (rsp_v),
		.o_ddata  (rsp)
	);

	i2css_xfer #(.W(16)) u_evt_xfer (
		.i_sclk   (i_link_clk),
		.i_srst   (lrst),
		.i_svalid (evt_v_q),
		.i_sdata  (evt_q),
		.o_sbusy  (),
		.i_dclk   (i_clk),
		.i_drst   (i_rst),
		.o_dvalid (evt_v),
		.o_ddata  (evt)
	);

	// ----------------------------------------------------------------
	// Bus engine on the link clock
	// ----------------------------------------------------------------
	i2css_pkg::i2css_cfg_t    lcfg_q;
	i2css_pkg::i2css_lstate_t lstate_q;
	i2css_pkg::i2css_next_t   next_q;
	logic       scl_p_q;
	logic       sda_p_q;
	logic       busy_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [6:0] tmr_q;
	logic       rd_q;
	logic       gcall_q;
	logic       rxack_q;
	logic       last_q;
	logic       nack_q;
	logic       addressed_q;
	logic       na_wait_q;
	logic       start_pend_q;
	logic       sda_oe_q;
	logic       scl_oe_q;
	logic       wake_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       gc_hit;
	logic       addr_hit;
	logic [7:0] aack_code;

	assign scl_rise  = pin_s[1] && !scl_p_q;
	assign scl_fall  = !pin_s[1] && scl_p_q;
	assign start_det = pin_s[1] && scl_p_q && sda_p_q && !pin_s[0];
	assign stop_det  = pin_s[1] && scl_p_q && !sda_p_q && pin_s[0];
	assign gc_hit    = sh_q[7:1] == `I2CSS_GCALL && !sh_q[0] &&
		lcfg_q.own[0]; // RQ6
	assign addr_hit  = lcfg_q.ack && !na_wait_q && // RQ13
		(sh_q[7:1] == lcfg_q.own[7:1] || gc_hit); // RQ5
	assign aack_code = gcall_q ?
		(lcfg_q.arb ? `I2CSS_S_ARB_GC : `I2CSS_S_GC) :
		rd_q ? (lcfg_q.arb ? `I2CSS_S_ARB_R : `I2CSS_S_SLA_R) : // RQ10
		(lcfg_q.arb ? `I2CSS_S_ARB_W : `I2CSS_S_SLA_W);

	always_ff @(posedge i_link_clk)
	begin
		if (lrst)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			busy_q  <= 1'b0;
		end
		else
		begin
			scl_p_q <= pin_s[1];
			sda_p_q <= pin_s[0];
			if (start_det)
				busy_q <= 1'b1;
			else if (stop_det)
				busy_q <= 1'b0;
		end
	end

	always_ff @(posedge i_link_clk)
	begin
		if (lrst)
			lcfg_q <= '0;
		else if (cfg_v)
			lcfg_q <= cfg_in;
	end

	// Free-state events other than nacked received data never stretch, so a master clocking on reads ones.
	always_ff @(posedge i_link_clk)
	begin
		if (lrst || !lcfg_q.en)
		begin
			lstate_q     <= i2css_pkg::LK_IDLE;
			next_q       <= i2css_pkg::NX_FREE;
			cnt_q        <= 4'h0;
			sh_q         <= 8'h00;
			tmr_q        <= 7'h00;
			rd_q         <= 1'b0;
			gcall_q      <= 1'b0;
			rxack_q      <= 1'b0;
			last_q       <= 1'b0;
			nack_q       <= 1'b0;
			addressed_q  <= 1'b0;
			na_wait_q    <= 1'b0;
			start_pend_q <= 1'b0;
			sda_oe_q     <= 1'b0;
			scl_oe_q     <= 1'b0;
			wake_q       <= 1'b0;
			evt_v_q      <= 1'b0;
			evt_q        <= '0;
		end
		else
		begin
			evt_v_q <= 1'b0;
			if (rsp_v)
			begin
				na_wait_q <= 1'b0; // RQ2
				wake_q    <= 1'b0;
				if (next_q == i2css_pkg::NX_FREE)
					start_pend_q <= rsp.start; // RQ3
			end
			if ((start_det || stop_det) && lstate_q != i2css_pkg::LK_GEN)
			begin
				if (addressed_q)
				begin
					evt_v_q      <= 1'b1;
					evt_q.code   <= `I2CSS_S_STOP; // RQ4
					next_q       <= i2css_pkg::NX_FREE;
					na_wait_q    <= 1'b1;
					addressed_q  <= 1'b0;
				end
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				cnt_q    <= 4'h0;
				lstate_q <= start_det ? i2css_pkg::LK_ADDR :
					i2css_pkg::LK_IDLE;
			end
			else
			begin
				case (lstate_q)
					i2css_pkg::LK_IDLE:
					begin
						if (start_pend_q && !busy_q && pin_s == 2'h3)
						begin
							sda_oe_q <= 1'b1; // RQ3
							tmr_q    <= 7'h00;
							lstate_q <= i2css_pkg::LK_GEN;
						end
					end
					i2css_pkg::LK_GEN:
					begin
						tmr_q <= tmr_q + 7'h01;
						if (tmr_q == 7'(HOLD_CYC - 1))
						begin
							evt_v_q      <= 1'b1;
							evt_q.code   <= `I2CSS_S_START;
							start_pend_q <= 1'b0;
							na_wait_q    <= 1'b1;
							next_q       <= i2css_pkg::NX_FREE;
							lstate_q     <= i2css_pkg::LK_WAIT;
						end
					end
					i2css_pkg::LK_ADDR:
					begin
						if (scl_rise)
						begin
							sh_q  <= {sh_q[6:0], pin_s[0]};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							cnt_q <= 4'h0;
							if (addr_hit)
							begin
								sda_oe_q <= 1'b1; // RQ14
								rd_q     <= sh_q[0];
								gcall_q  <= gc_hit;
								lstate_q <= i2css_pkg::LK_AACK;
							end
							else
								lstate_q <= i2css_pkg::LK_FREE;
						end
					end
					i2css_pkg::LK_AACK:
					begin
						if (scl_fall)
						begin
							sda_oe_q    <= 1'b0;
							scl_oe_q    <= 1'b1; // RQ15
							wake_q      <= sleep_s; // RQ14
							addressed_q <= 1'b1;
							evt_v_q     <= 1'b1;
							evt_q.code  <= aack_code; // RQ9
							next_q      <= rd_q ? i2css_pkg::NX_TX :
								i2css_pkg::NX_RX; // RQ8
							lstate_q    <= i2css_pkg::LK_WAIT;
						end
					end
					i2css_pkg::LK_WAIT:
					begin
						if (rsp_v)
						begin
							scl_oe_q <= 1'b0;
							cnt_q    <= 4'h0;
							case (next_q)
								i2css_pkg::NX_RX:
								begin
									rxack_q  <= rsp.ack; // RQ1
									lstate_q <= i2css_pkg::LK_RX;
								end
								i2css_pkg::NX_TX:
								begin
									sda_oe_q <= !rsp.data[7];
									sh_q     <= {rsp.data[6:0], 1'b0};
									last_q   <= !rsp.ack; // RQ19
									lstate_q <= i2css_pkg::LK_TX;
								end
								default:
								begin
									sda_oe_q    <= 1'b0;
									addressed_q <= 1'b0;
									lstate_q    <= i2css_pkg::LK_FREE;
								end
							endcase
						end
					end
					i2css_pkg::LK_RX:
					begin
						if (scl_rise)
						begin
							sh_q  <= {sh_q[6:0], pin_s[0]};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							sda_oe_q <= rxack_q; // RQ1
							lstate_q <= i2css_pkg::LK_RACK;
						end
					end
					i2css_pkg::LK_RACK:
					begin
						if (scl_fall)
						begin
							sda_oe_q   <= 1'b0;
							scl_oe_q   <= 1'b1;
							evt_v_q    <= 1'b1;
							evt_q.data <= sh_q;
							evt_q.code <= gcall_q ?
								(rxack_q ? `I2CSS_S_GC_ACK : `I2CSS_S_GC_NACK) :
								(rxack_q ? `I2CSS_S_RX_ACK : `I2CSS_S_RX_NACK);
							if (rxack_q)
								next_q <= i2css_pkg::NX_RX;
							else
							begin
								next_q      <= i2css_pkg::NX_FREE; // RQ18
								na_wait_q   <= 1'b1;
								addressed_q <= 1'b0;
							end
							lstate_q <= i2css_pkg::LK_WAIT;
						end
					end
					i2css_pkg::LK_TX:
					begin
						if (scl_rise)
							cnt_q <= cnt_q + 4'h1;
						else if (scl_fall && cnt_q == 4'h8)
						begin
							sda_oe_q <= 1'b0;
							lstate_q <= i2css_pkg::LK_TACK;
						end
						else if (scl_fall)
						begin
							sda_oe_q <= !sh_q[7];
							sh_q     <= {sh_q[6:0], 1'b0};
						end
					end
					i2css_pkg::LK_TACK:
					begin
						if (scl_rise)
							nack_q <= pin_s[0];
						else if (scl_fall)
						begin
							evt_v_q <= 1'b1;
							if (nack_q || last_q)
							begin
								evt_q.code  <= nack_q ? `I2CSS_S_TX_NACK :
									`I2CSS_S_TX_LAST; // RQ11
								next_q      <= i2css_pkg::NX_FREE;
								na_wait_q   <= 1'b1;
								addressed_q <= 1'b0;
								lstate_q    <= i2css_pkg::LK_FREE; // RQ12
							end
							else
							begin
								evt_q.code <= `I2CSS_S_TX_ACK;
								scl_oe_q   <= 1'b1;
								next_q     <= i2css_pkg::NX_TX;
								lstate_q   <= i2css_pkg::LK_WAIT;
							end
						end
					end
					i2css_pkg::LK_FREE:
						lstate_q <= i2css_pkg::LK_FREE;
					default:
						lstate_q <= i2css_pkg::LK_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_link_clk)
	begin
		o_scl_out <= 1'b0;
		o_sda_out <= 1'b0;
	end

	assign o_scl_oe = scl_oe_q;
	assign o_sda_oe = sda_oe_q;
	assign o_wake   = wake_q;
endmodule // i2css_top

// [tb/i2css_checker.sv]
// Concurrent checks on the slave engine's register port and bus pins.
`timescale 1ns/1ps
module i2css_checker (
	input wire logic       i_clk,        // Clock.
	input wire logic       i_rst,        // Reset.
	input wire logic [1:0] i_addr,       // Index.
	input wire logic [7:0] i_wdata,      // Data in.
	input wire logic       i_wr,         // Write.
	input wire logic       i_rd,         // Read.
	input wire logic [7:0] o_rdata,      // Data out.
	input wire logic       i_deep_sleep, // Sleep.
	input wire logic       i_link_clk,   // Link clock.
	input wire logic       i_scl,        // Clock line.
	input wire logic       o_scl_out,    // Clock drive.
	input wire logic       o_scl_oe,     // Clock hold.
	input wire logic       o_sda_out,    // Data drive.
	input wire logic       o_sda_oe,     // Data pull.
	input wire logic       o_wake        // Wake.
);
	// Cycles since the last flag clear, saturating at all ones.
	logic [7:0] clr_age_q;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			clr_age_q <= 8'hFF;
		else if (i_wr && i_addr == 2'h1 && i_wdata[7])
			clr_age_q <= 8'h00;
		else if (clr_age_q != 8'hFF)
			clr_age_q <= clr_age_q + 8'h01;
	end
	property p_rd_idle;
		@(posedge i_clk) disable iff (i_rst) !$past(i_rd) |-> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	property p_stat_b2;
		@(posedge i_clk) disable iff (i_rst)
		$past(i_rd) && $past(i_addr) == 2'h2 |-> !o_rdata[2];
	endproperty
	a_stat_b2: assert property (p_stat_b2)
		else $error("status bit 2 set");
	property p_scl_rel;
		@(posedge i_clk) disable iff (i_rst) $fell(o_scl_oe) |-> clr_age_q < 8'hC8;
	endproperty
	a_scl_rel: assert property (p_scl_rel)
		else $error("clock hold ended without a flag clear");
	property p_wake_rel;
		@(posedge i_clk) disable iff (i_rst) $fell(o_wake) |-> clr_age_q < 8'hC8;
	endproperty
	a_wake_rel: assert property (p_wake_rel)
		else $error("wake ended without a flag clear");
	property p_wake_slp;
		@(posedge i_link_clk) disable iff (i_rst) $rose(o_wake) |-> i_deep_sleep;
	endproperty
	a_wake_slp: assert property (p_wake_slp)
		else $error("wake raised while awake");
	property p_wake_hold;
		@(posedge i_link_clk) disable iff (i_rst)
		$rose(o_wake) |-> ##[0:40] o_scl_oe;
	endproperty
	a_wake_hold: assert property (p_wake_hold)
		else $error("no clock hold after wake match");
	property p_hold_low;
		@(posedge i_link_clk) disable iff (i_rst) $rose(o_scl_oe) |-> !i_scl;
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("clock hold began with clock high");
	property p_open_drn;
		@(posedge i_clk) disable iff (i_rst) !o_scl_out && !o_sda_out;
	endproperty
	a_open_drn: assert property (p_open_drn)
		else $error("line driven high");
	c_wake: cover property (@(posedge i_link_clk) $rose(o_wake));
	c_rel: cover property (@(posedge i_clk) $fell(o_scl_oe));
	c_start: cover property (@(posedge i_link_clk) $rose(o_sda_oe) && i_scl);
endmodule // i2css_checker

// [tb/i2css_master_model.sv]
// Behavioural two-wire bus master facing the slave engine.
`timescale 1ns/1ps
module i2css_master_model (
	input  wire logic i_scl,    // Clock line level.
	input  wire logic i_sda,    // Data line level.
	output logic      o_scl_oe, // Holds clock low.
	output logic      o_sda_oe  // Holds data low.
);
	localparam int HALF = 512;
	initial
	begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
	end
	// The slave may stretch the clock; the wait is bounded.
	task automatic scl_up();
		int n = 0;
		o_scl_oe = 1'b0;
		while (i_scl !== 1'b1 && n < 50000)
		begin
			#8;
			n++;
		end
	endtask
	task automatic bit_io(input logic d, output logic s);
		o_sda_oe = ~d;
		#(HALF);
		scl_up();
		#(HALF / 2);
		s = i_sda;
		#(HALF / 2);
		o_scl_oe = 1'b1;
	endtask
	task automatic start_c();
		o_sda_oe = 1'b1;
		#(HALF);
		o_scl_oe = 1'b1;
	endtask
	task automatic stop_c();
		o_sda_oe = 1'b1;
		#(HALF);
		scl_up();
		#(HALF);
		o_sda_oe = 1'b0;
		#(HALF);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic get_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(~ack, s);
	endtask
endmodule // i2css_master_model

// [tb/testbench.sv]
// Self-checking bench for the slave status engine.
`timescale 1ns/1ps
module testbench;
	logic       clk, lclk, rst, wr, rd, arb, sleep, m_scl, m_sda;
	logic       scl_out, scl_oe, sda_out, sda_oe, wake;
	logic [1:0] addr;
	logic [7:0] wdata, rdata;
	int         errors, samples_checked;
	// Open-drain lines with pull-ups.
	wire scl = !(m_scl || (scl_oe && !scl_out));
	wire sda = !(m_sda || (sda_oe && !sda_out));
	i2css_top uut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_arb_lost(arb),
		.i_deep_sleep(sleep), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
		.o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .o_wake(wake));
	i2css_master_model pm (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl),
		.o_sda_oe(m_sda));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #32 lclk = ~lclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		if (seen !== exp)
			errors++;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic chk_reg(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] v;
		rreg(a, v);
		check(v, e);
	endtask
	// Waits for the flag, bounded, then compares the status code.
	task automatic stat_is(input logic [7:0] code);
		logic [7:0] v = 8'h00;
		int n = 0;
		while (v[7] !== 1'b1 && n < 2000)
		begin
			rreg(2'h1, v);
			n++;
		end
		check(v & 8'h80, 8'h80);
		chk_reg(2'h2, code);
	endtask
	task automatic sla(input logic [7:0] b, input logic ack);
		pm.start_c();
		send(b, ack);
	endtask
	task automatic send(input logic [7:0] b, input logic ack);
		logic a;
		pm.put_byte(b, a);
		check({7'h00, a}, {7'h00, ack});
	endtask
	task automatic recv(input logic [7:0] b, input logic ack);
		logic [7:0] v;
		pm.get_byte(v, ack);
		check(v, b);
	endtask
	task automatic leave();
		pm.stop_c();
		stat_is(8'hA0);
		wreg(2'h1, 8'hC4);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic s_regs();
		logic [7:0] v;
		chk_reg(2'h0, 8'h00);
		chk_reg(2'h2, 8'hF8);
		wreg(2'h3, 8'h5A);
		rreg(2'h1, v);
		check(v & 8'h08, 8'h08);
		wreg(2'h0, 8'hA4);
		wreg(2'h1, 8'h44);
		chk_reg(2'h0, 8'hA4);
		idle(300);
	endtask
	task automatic s_write();
		sla(8'hA4, 1'b1);
		stat_is(8'h60);
		wreg(2'h1, 8'hC4);
		send(8'h3C, 1'b1);
		stat_is(8'h80);
		wreg(2'h1, 8'h84);
		send(8'hC3, 1'b0);
		stat_is(8'h88);
		chk_reg(2'h3, 8'hC3);
		wreg(2'h1, 8'hC4);
		pm.stop_c();
		sla(8'hA4, 1'b1);
		stat_is(8'h60);
		wreg(2'h1, 8'hC4);
		leave();
	endtask
	task automatic s_gcall();
		sla(8'h00, 1'b0);
		pm.stop_c();
		wreg(2'h0, 8'hA5);
		idle(120);
		sla(8'h00, 1'b1);
		stat_is(8'h70);
		wreg(2'h1, 8'hC4);
		send(8'h11, 1'b1);
		stat_is(8'h90);
		wreg(2'h1, 8'h84);
		send(8'h22, 1'b0);
		stat_is(8'h98);
		chk_reg(2'h3, 8'h22);
		wreg(2'h1, 8'h84);
		pm.stop_c();
		idle(120);
		sla(8'hA4, 1'b0);
		pm.stop_c();
		wreg(2'h1, 8'h44);
		idle(120);
		sla(8'hA4, 1'b1);
		stat_is(8'h60);
		wreg(2'h1, 8'hC4);
		leave();
	endtask
	task automatic s_read();
		sla(8'hA5, 1'b1);
		stat_is(8'hA8);
		wreg(2'h3, 8'h96);
		wreg(2'h1, 8'hC4);
		recv(8'h96, 1'b1);
		stat_is(8'hB8);
		wreg(2'h3, 8'h5A);
		wreg(2'h1, 8'h84);
		recv(8'h5A, 1'b1);
		stat_is(8'hC8);
		wreg(2'h1, 8'hC4);
		recv(8'hFF, 1'b0);
		pm.stop_c();
		sla(8'hA5, 1'b1);
		stat_is(8'hA8);
		wreg(2'h3, 8'h01);
		wreg(2'h1, 8'h84);
		recv(8'h01, 1'b0);
		stat_is(8'hC0);
		wreg(2'h1, 8'hE4);
		pm.stop_c();
		stat_is(8'h08);
		check({7'h00, sda_oe}, 8'h01);
		wreg(2'h1, 8'hC4);
		idle(120);
		check({7'h00, sda_oe}, 8'h00);
	endtask
	task automatic s_arb_sleep();
		arb <= 1'b1;
		idle(1);
		arb <= 1'b0;
		sla(8'hA5, 1'b1);
		stat_is(8'hB0);
		wreg(2'h3, 8'h77);
		wreg(2'h1, 8'h84);
		recv(8'h77, 1'b0);
		stat_is(8'hC0);
		wreg(2'h1, 8'hC4);
		pm.stop_c();
		sleep <= 1'b1;
		idle(120);
		sla(8'hA4, 1'b1);
		stat_is(8'h60);
		check({6'h00, wake, scl_oe}, 8'h03);
		sleep <= 1'b0;
		wreg(2'h1, 8'hC4);
		idle(120);
		check({6'h00, wake, scl_oe}, 8'h00);
		leave();
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		arb = 1'b0;
		sleep = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		errors = 0;
		samples_checked = 0;
		idle(5);
		rst <= 1'b0;
		s_regs();
		s_write();
		s_gcall();
		s_read();
		s_arb_sleep();
		conclude();
	end
	initial
	begin
		#450000;
		errors++;
		conclude();
	end
endmodule // testbench
bind i2css_top i2css_checker chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_deep_sleep, .i_link_clk, .i_scl, .o_scl_out,
	.o_scl_oe, .o_sda_out, .o_sda_oe, .o_wake);
